// *** lpm_regs.svh ***
// Register map, field positions, reset values and timing counts for the power-mode controller
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
`define OFS_SYSCTL1 8'h00
`define OFS_SYSCTL2 8'h04
`define OFS_TMRMODE 8'h08
`define OFS_IEN1 8'h0c
`define OFS_IEN2 8'h10
`define OFS_STATUS 8'h14
`define SC1_STBY 7
`define SC1_STS_HI 6
`define SC1_STS_LO 4
`define SC1_LOW_SPEED_ON 3
`define SC1_MCS_HI 1
`define SC1_MCS_LO 0
`define SC2_DIRECT_TRANSFER_ON 3
`define SC2_MEDIUM_SPEED_ON 2
`define SC2_SCS_HI 1
`define SC2_SCS_LO 0
`define TMR_WSEL 3
`define IEN1_W 14
`define IEN2_DT 0
`define SC1_RST 8'h00
`define SC2_RST 8'h00
`define TMR_RST 8'h00
`define IEN1_RST 14'h0000
`define SETTLE_BASE_STATES 8192
`define SETTLE_MAX_SHIFT 3'h4
`define XTAL_MIN_SETTLE_MS 10
`define CNT_W 18
`endif

// *** lpm_pkg.sv ***
// Types shared by the power-mode controller
package lpm_pkg;
	typedef enum logic [2:0] {
		MODE_ACT_HS,
		MODE_ACT_MS,
		MODE_SUBACT,
		MODE_SLEEP_HS,
		MODE_SLEEP_MS,
		MODE_SUBSLEEP,
		MODE_WATCH,
		MODE_STANDBY
	} mode_e;
	typedef struct packed {
		logic periph;
		logic [7:0] edge_wakeup_inputs;
		logic [3:0] external_request_lines;
		logic timer_a;
	} wake_req_s;
	typedef struct packed {
		logic watch_src;
		logic [1:0] div_sel;
	} clk_cfg_s;
endpackage : lpm_pkg

// *** low_power_mode_controller.sv ***
// Power-mode sequencer with APB register access
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "lpm_regs.svh"
`default_nettype none
module low_power_mode_controller #(
	parameter int SETTLE_BASE = `SETTLE_BASE_STATES
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU side
	input wire logic sleep_exec,
	input wire logic cpu_imask,
	input wire logic timer_a_irq,
	input wire logic periph_irq,
	// Pins
	input wire logic [3:0] ext_req_pin,
	input wire logic [7:0] edge_wake_pin,
	// Mode outputs
	output lpm_pkg::mode_e mode,
	output lpm_pkg::clk_cfg_s cpu_clk,
	output logic cpu_halt,
	output logic periph_stop,
	output logic io_hiz,
	output logic settle_busy,
	output logic wake_exc,
	output logic dt_exc
);
	logic [7:0] sc1_q;
	logic [7:0] sc2_q;
	logic [7:0] tmr_q;
	logic [`IEN1_W-1:0] ien1_q;
	logic ien2_q;
	logic [3:0] ext_meta_q;
	logic [3:0] ext_sync_q;
	logic [7:0] edge_meta_q;
	logic [7:0] edge_sync_q;
	lpm_pkg::mode_e mode_q;
	lpm_pkg::mode_e mode_d;
	lpm_pkg::mode_e target_q;
	lpm_pkg::mode_e target_d;
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] cnt_d;
	logic settling_q;
	logic settling_d;
	logic dt_pend_q;
	logic dt_pend_d;
	logic wake_d;
	logic dt_d;
	lpm_pkg::wake_req_s req;
	lpm_pkg::wake_req_s live;
	logic stby;
	logic low_speed_on;
	logic medium_speed_on;
	logic direct_transfer_on;
	logic wsel;
	logic dt_ok;
	logic acc_wr;
	lpm_pkg::mode_e act_tgt;

	// Settling count from the three-bit code
	function automatic logic [`CNT_W-1:0] settle_cnt(input logic [2:0] code);
		logic [2:0] sh;
		sh = code[2] ? `SETTLE_MAX_SHIFT : code;
		settle_cnt = `CNT_W'(SETTLE_BASE << sh);
	endfunction : settle_cnt

	// High-speed or medium-speed variant of a mode, keyed by the medium-speed bit
	function automatic lpm_pkg::mode_e pick(input logic ms, input lpm_pkg::mode_e hs,
		input lpm_pkg::mode_e msm);
		pick = ms ? msm : hs;
	endfunction : pick

	// Modes in which the CPU runs a program
	function automatic logic is_running(input lpm_pkg::mode_e m);
		is_running = (m == lpm_pkg::MODE_ACT_HS) || (m == lpm_pkg::MODE_ACT_MS) || (m == lpm_pkg::MODE_SUBACT);
	endfunction : is_running

	assign stby = sc1_q[`SC1_STBY];
	assign low_speed_on = sc1_q[`SC1_LOW_SPEED_ON];
	assign medium_speed_on = sc2_q[`SC2_MEDIUM_SPEED_ON];
	assign direct_transfer_on = sc2_q[`SC2_DIRECT_TRANSFER_ON];
	assign wsel = tmr_q[`TMR_WSEL];
	assign req.periph = periph_irq;
	assign req.edge_wakeup_inputs = edge_sync_q;
	assign req.external_request_lines = ext_sync_q;
	assign req.timer_a = timer_a_irq;
	// Masked or disabled requests are invisible to every mode
	assign live = cpu_imask ? '0 : (req & ien1_q);
	// Without its enable a direct transfer decays into a plain sleep
	assign dt_ok = direct_transfer_on & ien2_q & ~cpu_imask;
	assign act_tgt = pick(medium_speed_on, lpm_pkg::MODE_ACT_HS, lpm_pkg::MODE_ACT_MS);
	assign acc_wr = psel & penable & pwrite & pready;

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_meta_q <= '0;
			ext_sync_q <= '0;
			edge_meta_q <= '0;
			edge_sync_q <= '0;
		end
		else if (ce)
		begin
			ext_meta_q <= ext_req_pin;
			ext_sync_q <= ext_meta_q;
			edge_meta_q <= edge_wake_pin;
			edge_sync_q <= edge_meta_q;
		end
	end

	// Next mode
	always_comb
	begin
		mode_d = mode_q;
		target_d = target_q;
		cnt_d = cnt_q;
		settling_d = settling_q;
		dt_pend_d = dt_pend_q;
		wake_d = 1'b0;
		dt_d = 1'b0;
		if (settling_q)
		begin
			// Clock comes back only after the full count
			if (cnt_q == '0)
			begin
				settling_d = 1'b0;
				mode_d = target_q;
				wake_d = ~dt_pend_q;
				dt_d = dt_pend_q;
				dt_pend_d = 1'b0;
			end
			else
				cnt_d = cnt_q - `CNT_W'(1);
		end
		else
		begin
			case (mode_q)
				lpm_pkg::MODE_ACT_HS, lpm_pkg::MODE_ACT_MS:
				begin
					if (sleep_exec)
					begin
						if (dt_ok && !stby && !low_speed_on && (medium_speed_on != (mode_q == lpm_pkg::MODE_ACT_MS)))
						begin
							mode_d = act_tgt;
							dt_d = 1'b1;
						end
						else if (dt_ok && stby && low_speed_on && wsel)
						begin
							mode_d = lpm_pkg::MODE_SUBACT;
							dt_d = 1'b1;
						end
						else if (stby && wsel)
							mode_d = lpm_pkg::MODE_WATCH;
						else if (stby && !low_speed_on)
							mode_d = lpm_pkg::MODE_STANDBY;
						else if (!stby && !low_speed_on)
							mode_d = pick(medium_speed_on, lpm_pkg::MODE_SLEEP_HS, lpm_pkg::MODE_SLEEP_MS);
					end
				end
				lpm_pkg::MODE_SUBACT:
				begin
					if (sleep_exec)
					begin
						if (dt_ok && stby && !low_speed_on && wsel)
						begin
							mode_d = lpm_pkg::MODE_WATCH;
							target_d = act_tgt;
							cnt_d = settle_cnt(sc1_q[`SC1_STS_HI:`SC1_STS_LO]);
							settling_d = 1'b1;
							dt_pend_d = 1'b1;
						end
						else if (stby && wsel)
							mode_d = lpm_pkg::MODE_WATCH;
						else if (!stby && low_speed_on && wsel)
							mode_d = lpm_pkg::MODE_SUBSLEEP;
					end
				end
				lpm_pkg::MODE_SLEEP_HS, lpm_pkg::MODE_SLEEP_MS:
				begin
					if (|live)
					begin
						mode_d = (mode_q == lpm_pkg::MODE_SLEEP_MS) ? lpm_pkg::MODE_ACT_MS
							: lpm_pkg::MODE_ACT_HS;
						wake_d = 1'b1;
					end
				end
				lpm_pkg::MODE_SUBSLEEP:
				begin
					if (live.timer_a || |live.external_request_lines || |live.edge_wakeup_inputs)
					begin
						mode_d = lpm_pkg::MODE_SUBACT;
						wake_d = 1'b1;
					end
				end
				lpm_pkg::MODE_WATCH:
				begin
					if (live.timer_a || live.external_request_lines[0])
					begin
						if (low_speed_on)
						begin
							mode_d = lpm_pkg::MODE_SUBACT;
							wake_d = 1'b1;
						end
						else
						begin
							// Fast clock only returns once the oscillator has settled
							target_d = act_tgt;
							cnt_d = settle_cnt(sc1_q[`SC1_STS_HI:`SC1_STS_LO]);
							settling_d = 1'b1;
						end
					end
				end
				lpm_pkg::MODE_STANDBY:
				begin
					// Only the two lowest request lines restart the oscillator
					if (|live.external_request_lines[1:0])
					begin
						target_d = act_tgt;
						cnt_d = settle_cnt(sc1_q[`SC1_STS_HI:`SC1_STS_LO]);
						settling_d = 1'b1;
					end
				end
				default:
					mode_d = lpm_pkg::MODE_ACT_HS;
			endcase
		end
	end

	// Mode state; the reset pin returns every mode to high-speed active
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= lpm_pkg::MODE_ACT_HS;
			target_q <= lpm_pkg::MODE_ACT_HS;
			cnt_q <= '0;
			settling_q <= 1'b0;
			dt_pend_q <= 1'b0;
		end
		else if (ce)
		begin
			mode_q <= mode_d;
			target_q <= target_d;
			cnt_q <= cnt_d;
			settling_q <= settling_d;
			dt_pend_q <= dt_pend_d;
		end
	end

	// Registered mode outputs, decoded from the next state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode <= lpm_pkg::MODE_ACT_HS;
			cpu_clk <= '0;
			cpu_halt <= 1'b0;
			periph_stop <= 1'b0;
			io_hiz <= 1'b0;
			settle_busy <= 1'b0;
		end
		else if (ce)
		begin
			mode <= mode_d;
			settle_busy <= settling_d;
			// The CPU keeps its clock only in the three running modes
			cpu_halt <= !is_running(mode_d);
			// Peripherals stop in watch, subsleep and standby; timer A still wakes watch and subsleep, but standby ignores it
			periph_stop <= (mode_d == lpm_pkg::MODE_WATCH) || (mode_d == lpm_pkg::MODE_SUBSLEEP)
				|| (mode_d == lpm_pkg::MODE_STANDBY);
			io_hiz <= (mode_d == lpm_pkg::MODE_STANDBY);
			case (mode_d)
				lpm_pkg::MODE_SUBACT, lpm_pkg::MODE_SUBSLEEP, lpm_pkg::MODE_WATCH:
					cpu_clk <= '{watch_src: 1'b1, div_sel: sc2_q[`SC2_SCS_HI:`SC2_SCS_LO]};
				lpm_pkg::MODE_ACT_MS, lpm_pkg::MODE_SLEEP_MS:
					cpu_clk <= '{watch_src: 1'b0, div_sel: sc1_q[`SC1_MCS_HI:`SC1_MCS_LO]};
				default:
					cpu_clk <= '0;
			endcase
		end
	end

	// Exception pulses: one cycle each, launched with the mode change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wake_exc <= 1'b0;
			dt_exc <= 1'b0;
		end
		else if (ce)
		begin
			wake_exc <= wake_d;
			dt_exc <= dt_d;
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sc1_q <= `SC1_RST;
			sc2_q <= `SC2_RST;
			tmr_q <= `TMR_RST;
			ien1_q <= `IEN1_RST;
			ien2_q <= 1'b0;
		end
		else if (ce && acc_wr)
		begin
			case (paddr)
				`OFS_SYSCTL1:
					sc1_q <= pwdata[7:0];
				`OFS_SYSCTL2:
				begin
					sc2_q[7:`SC2_SCS_HI+1] <= pwdata[7:`SC2_SCS_HI+1];
					// Divider is frozen while the CPU runs from it in subactive mode
					if (mode_q != lpm_pkg::MODE_SUBACT)
						sc2_q[`SC2_SCS_HI:`SC2_SCS_LO] <= pwdata[`SC2_SCS_HI:`SC2_SCS_LO];
				end
				`OFS_TMRMODE:
					tmr_q <= pwdata[7:0];
				`OFS_IEN1:
					ien1_q <= pwdata[`IEN1_W-1:0];
				`OFS_IEN2:
					ien2_q <= pwdata[`IEN2_DT];
				default:
					sc1_q <= sc1_q;
			endcase
		end
	end

	// APB answer: ready one cycle after setup, data latched at setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else if (ce)
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable)
			begin
				case (paddr)
					`OFS_SYSCTL1:
						prdata <= {24'h000000, sc1_q};
					`OFS_SYSCTL2:
						prdata <= {24'h000000, sc2_q};
					`OFS_TMRMODE:
						prdata <= {24'h000000, tmr_q};
					`OFS_IEN1:
						prdata <= {18'h00000, ien1_q};
					`OFS_IEN2:
						prdata <= {31'h00000000, ien2_q};
					`OFS_STATUS:
						prdata <= {28'h0000000, settling_q, mode_q};
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule : low_power_mode_controller
`default_nettype wire

// *** lpm_properties.sv ***
// Checker for the power-mode controller outputs
`timescale 1ns/100ps
`default_nettype none
module lpm_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched ports
	input wire lpm_pkg::mode_e mode,
	input wire lpm_pkg::clk_cfg_s cpu_clk,
	input wire logic cpu_imask,
	input wire logic cpu_halt,
	input wire logic periph_stop,
	input wire logic io_hiz,
	input wire logic settle_busy,
	input wire logic wake_exc,
	input wire logic dt_exc
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_halt_run: assert property (
		cpu_halt == !(mode inside {lpm_pkg::MODE_ACT_HS, lpm_pkg::MODE_ACT_MS, lpm_pkg::MODE_SUBACT}))
		else $error("halt mismatch");
	chk_hiz_stby: assert property (io_hiz == (mode == lpm_pkg::MODE_STANDBY))
		else $error("hiz mismatch");
	chk_stop_low: assert property (
		periph_stop == (mode inside {lpm_pkg::MODE_WATCH, lpm_pkg::MODE_SUBSLEEP, lpm_pkg::MODE_STANDBY}))
		else $error("stop mismatch");
	chk_sub_clk: assert property (mode == lpm_pkg::MODE_SUBACT |-> cpu_clk.watch_src)
		else $error("sub clock");
	chk_hs_clk: assert property (mode == lpm_pkg::MODE_ACT_HS |-> cpu_clk == 3'h0)
		else $error("hs clock");
	// Settling excluded: the wake was already taken
	chk_mask_hold: assert property (cpu_imask && cpu_halt && !settle_busy |=> cpu_halt)
		else $error("masked wake");
	chk_dt_pulse: assert property (dt_exc |=> !dt_exc)
		else $error("dt pulse");
	chk_wake_run: assert property (wake_exc |-> !cpu_halt ##1 !wake_exc)
		else $error("wake pulse");
	chk_settle_in: assert property (
		$rose(settle_busy) |-> mode inside {lpm_pkg::MODE_WATCH, lpm_pkg::MODE_STANDBY})
		else $error("settle mode");
	chk_settle_out: assert property ($fell(settle_busy) |-> ##[0:1] !cpu_halt)
		else $error("settle exit");
	cov_direct: cover property (dt_exc);
	cov_sub_wake: cover property (wake_exc && mode == lpm_pkg::MODE_SUBACT);
	cov_settle: cover property ($fell(settle_busy));
endmodule : lpm_checker
bind low_power_mode_controller lpm_checker lpm_checker_inst (.pclk, .presetn, .mode, .cpu_clk, .cpu_imask,
	.cpu_halt, .periph_stop, .io_hiz, .settle_busy, .wake_exc, .dt_exc);
`default_nettype wire

// *** cpu_model.sv ***
// CPU core and interrupt sources facing the controller
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
	// Clock
	input wire logic pclk,
	// From controller
	input wire logic wake_exc,
	// CPU
	output logic sleep_exec,
	output logic cpu_imask,
	// Requests
	output logic timer_a_irq,
	output logic periph_irq,
	output logic [3:0] ext_req_pin,
	output logic [7:0] edge_wake_pin
);
	lpm_pkg::wake_req_s r_q = '0;
	initial
	begin
		sleep_exec = 1'b0;
		cpu_imask = 1'b0;
	end
	assign {periph_irq, edge_wake_pin, ext_req_pin, timer_a_irq} = r_q;
	task slp;
		@(posedge pclk);
		sleep_exec <= 1'b1;
		@(posedge pclk);
		sleep_exec <= 1'b0;
		@(negedge pclk);
	endtask : slp
	task msk(input logic m);
		@(posedge pclk);
		cpu_imask <= m;
	endtask : msk
	task irq(input lpm_pkg::wake_req_s v);
		@(posedge pclk);
		r_q <= v;
	endtask : irq
	// Requests stand until exception handling takes them
	always @(posedge pclk)
		if (wake_exc)
			r_q <= '0;
endmodule : cpu_model
`default_nettype wire

// *** low_power_mode_controller_bench.sv ***
// Self-checking bench for the power-mode controller
`timescale 1ns/100ps
`include "lpm_regs.svh"
`default_nettype none
module low_power_mode_controller_bench;
	localparam int SB = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, sleep_exec, cpu_imask, timer_a_irq, periph_irq;
	logic cpu_halt, periph_stop, io_hiz, settle_busy, wake_exc, dt_exc;
	logic [3:0] ext_req_pin;
	logic [7:0] edge_wake_pin;
	lpm_pkg::mode_e mode;
	lpm_pkg::clk_cfg_s cpu_clk;
	int failures = 0;
	int n_tests = 0;
	always #20 pclk = ~pclk;
	low_power_mode_controller #(.SETTLE_BASE(SB)) low_power_mode_controller_inst (.pclk, .presetn, .ce,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .cpu_imask,
		.timer_a_irq, .periph_irq, .ext_req_pin, .edge_wake_pin, .mode, .cpu_clk, .cpu_halt, .periph_stop,
		.io_hiz, .settle_busy, .wake_exc, .dt_exc);
	cpu_model cpu_model_inst (.pclk, .wake_exc, .sleep_exec, .cpu_imask, .timer_a_irq, .periph_irq,
		.ext_req_pin, .edge_wake_pin);
	task end_of_test;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task tmo;
		failures++;
		end_of_test;
	endtask : tmo
	task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			tmo;
	endtask : ap
	task go(input logic [7:0] s1, input logic [7:0] s2, input logic tw, input lpm_pkg::mode_e m, input logic dt);
		ap(1'b1, `OFS_SYSCTL1, {24'h0, s1});
		ap(1'b1, `OFS_SYSCTL2, {24'h0, s2});
		ap(1'b1, `OFS_TMRMODE, {28'h0, tw, 3'h0});
		cpu_model_inst.slp;
		chk(mode, m);
		chk(dt_exc, dt);
	endtask : go
	// A negative count skips the timing check; up to two cycles of slack above, none below
	task wt(input lpm_pkg::mode_e m, input int n, input logic [1:0] x);
		int c;
		c = 0;
		while (mode !== m && c < 300)
		begin
			@(negedge pclk);
			c++;
		end
		if (mode !== m)
			tmo;
		else
		begin
			if (n >= 0)
				chk(c >= n && c <= n + 2, 1'b1);
			chk({wake_exc, dt_exc}, x);
		end
	endtask : wt
	task s_reset;
		chk(mode, lpm_pkg::MODE_ACT_HS);
		ap(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		ap(1'b0, 8'h18, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		ap(1'b1, `OFS_IEN1, 32'h3fff);
		ap(1'b0, `OFS_IEN1, 32'h0);
		chk(rd, 32'h3fff);
	endtask : s_reset
	task s_sleep;
		for (int m = 0; m < 2; m++)
		begin
			go(8'h00, m ? 8'h04 : 8'h00, 1'b0, m ? lpm_pkg::MODE_SLEEP_MS : lpm_pkg::MODE_SLEEP_HS, 1'b0);
			cpu_model_inst.irq(14'h2000);
			wt(m ? lpm_pkg::MODE_ACT_MS : lpm_pkg::MODE_ACT_HS, -1, 2'b10);
		end
	endtask : s_sleep
	task s_mask;
		cpu_model_inst.msk(1'b1);
		go(8'h00, 8'h00, 1'b0, lpm_pkg::MODE_SLEEP_HS, 1'b0);
		cpu_model_inst.irq(14'h2000);
		repeat (10) @(negedge pclk);
		chk(mode, lpm_pkg::MODE_SLEEP_HS);
		cpu_model_inst.msk(1'b0);
		wt(lpm_pkg::MODE_ACT_HS, -1, 2'b10);
	endtask : s_mask
	task s_direct;
		ap(1'b1, `OFS_IEN2, 32'h1);
		go(8'h00, 8'h0c, 1'b0, lpm_pkg::MODE_ACT_MS, 1'b1);
		go(8'h00, 8'h08, 1'b0, lpm_pkg::MODE_ACT_HS, 1'b1);
		go(8'h88, 8'h08, 1'b1, lpm_pkg::MODE_SUBACT, 1'b1);
		chk(cpu_clk, 3'h4);
		ap(1'b1, `OFS_SYSCTL2, 32'h09);
		repeat (2) @(negedge pclk);
		chk(cpu_clk, 3'h4);
		go(8'hd0, 8'h08, 1'b1, lpm_pkg::MODE_WATCH, 1'b0);
		wt(lpm_pkg::MODE_ACT_HS, SB << 4, 2'b01);
	endtask : s_direct
	task s_sub;
		go(8'h88, 8'h09, 1'b1, lpm_pkg::MODE_SUBACT, 1'b1);
		chk(cpu_clk, 3'h5);
		for (int b = 0; b < 13; b++)
		begin
			go(8'h08, 8'h00, 1'b1, lpm_pkg::MODE_SUBSLEEP, 1'b0);
			cpu_model_inst.irq(14'h0001 << b);
			wt(lpm_pkg::MODE_SUBACT, -1, 2'b10);
		end
		go(8'h08, 8'h00, 1'b1, lpm_pkg::MODE_SUBSLEEP, 1'b0);
		cpu_model_inst.irq(14'h2000);
		repeat (10) @(negedge pclk);
		chk(mode, lpm_pkg::MODE_SUBSLEEP);
		cpu_model_inst.irq(14'h0001);
		wt(lpm_pkg::MODE_SUBACT, -1, 2'b10);
		go(8'h88, 8'h00, 1'b1, lpm_pkg::MODE_WATCH, 1'b0);
		cpu_model_inst.irq(14'h0002);
		wt(lpm_pkg::MODE_SUBACT, -1, 2'b10);
		go(8'h93, 8'h0c, 1'b1, lpm_pkg::MODE_WATCH, 1'b0);
		wt(lpm_pkg::MODE_ACT_MS, SB << 1, 2'b01);
		chk(cpu_clk, 3'h3);
	endtask : s_sub
	task s_stby;
		go(8'h80, 8'h00, 1'b0, lpm_pkg::MODE_STANDBY, 1'b0);
		cpu_model_inst.irq(14'h0004);
		wt(lpm_pkg::MODE_ACT_HS, -1, 2'b10);
		go(8'h80, 8'h06, 1'b1, lpm_pkg::MODE_WATCH, 1'b0);
		chk(cpu_clk, 3'h6);
		cpu_model_inst.irq(14'h0001);
		wt(lpm_pkg::MODE_ACT_MS, SB + 1, 2'b10);
		ap(1'b1, `OFS_IEN2, 32'h0);
		go(8'h00, 8'h0c, 1'b0, lpm_pkg::MODE_SLEEP_MS, 1'b0);
	endtask : s_stby
	task s_rst;
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk(mode, lpm_pkg::MODE_ACT_HS);
		@(posedge pclk);
		presetn <= 1'b1;
		ap(1'b0, `OFS_SYSCTL2, 32'h0);
		chk(rd, 32'h0);
	endtask : s_rst
	// A sleep pulse while the enable is low must be lost
	task s_ce;
		@(posedge pclk);
		ce <= 1'b0;
		cpu_model_inst.slp;
		chk(mode, lpm_pkg::MODE_ACT_HS);
		@(posedge pclk);
		ce <= 1'b1;
		repeat (2) @(negedge pclk);
		chk(mode, lpm_pkg::MODE_ACT_HS);
		cpu_model_inst.slp;
		chk(mode, lpm_pkg::MODE_SLEEP_HS);
	endtask : s_ce
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s_reset;
		s_sleep;
		s_mask;
		s_direct;
		s_sub;
		s_stby;
		s_rst;
		s_ce;
		end_of_test;
	end
endmodule : low_power_mode_controller_bench
`default_nettype wire
